// ### verilog/dmx_pkg.sv
package dmx_pkg;
  // ==========================================================
  // special-function register addresses
  localparam logic [7:0]  DMX_SFR_AUX_ZERO  = 8'h8E; // aux_control_zero
  localparam logic [7:0]  DMX_SFR_AUX_ONE   = 8'hA2; // aux_control_one
  localparam logic [7:0]  DMX_SFR_STACK     = 8'h81; // stack_pointer
  localparam logic [7:0]  DMX_SFR_PTR_LOW   = 8'h82; // pointer_low_byte
  localparam logic [7:0]  DMX_SFR_PTR_HIGH  = 8'h83; // pointer_high_byte
  localparam logic [7:0]  DMX_SFR_PORT2     = 8'hA0; // port 2 latch
  // ==========================================================
  // reset values
  localparam logic [7:0]  DMX_AUX_ZERO_RST  = 8'h00;
  localparam logic [7:0]  DMX_AUX_ONE_RST   = 8'h00;
  localparam logic [7:0]  DMX_STACK_RST     = 8'h07;
  localparam logic [7:0]  DMX_PORT2_RST     = 8'hFF;
  localparam logic [15:0] DMX_PTR_RST       = 16'h0000;
  // ==========================================================
  // field positions
  localparam int          DMX_AUX0_ALE_OFF_BIT = 0;
  localparam int          DMX_AUX0_DISABLE_BIT = 1; // internal_xram_disable
  localparam int          DMX_AUX1_SELECT_BIT  = 0; // pointer_select
  localparam int          DMX_AUX1_ZERO_BIT    = 2; // hard-wired zero
  localparam int          DMX_AUX1_FLAG_BIT    = 3; // user_flag_two
  // ==========================================================
  // expanded ram geometry and bus timing
  localparam logic [15:0] DMX_XRAM_LIMIT    = 16'h0300; // first ext addr
  localparam int          DMX_XRAM_DEPTH    = 768;
  localparam int          DMX_XRAM_AW       = 10;
  localparam real         DMX_CLK_NS        = 5.0;  // 200 mhz core clock
  localparam real         DMX_STROBE_NS     = 10.0; // least strobe width
  localparam int          DMX_STROBE_CYC    =
    (DMX_STROBE_NS / DMX_CLK_NS) < 1.0 ? 1 :
    int'($ceil(DMX_STROBE_NS / DMX_CLK_NS));
  // ==========================================================
  // access sequencer states
  typedef enum logic [2:0] {
    DMX_IDLE, DMX_IRAM, DMX_ICAP, DMX_ADDR, DMX_STROBE, DMX_HOLD, DMX_DONE
  } dmx_state_t;
endpackage

// ### verilog/dmx_xram_if.sv
`timescale 1ns/1ps
// ==========================================================
// link between sequencer and on-chip expanded ram
interface dmx_xram_if #(parameter int AW = 10);
  logic          en;    // access strobe, one cycle
  logic          we;    // write when high
  logic [AW-1:0] addr;  // word address
  logic [7:0]    wdata; // write byte
  logic [7:0]    rdata; // read byte, valid cycle after en
  modport ctrl (output en, output we, output addr, output wdata,
                input rdata);
  modport mem  (input en, input we, input addr, input wdata,
                output rdata);
endinterface

// ### verilog/dmx_xram.sv
`timescale 1ns/1ps
// ==========================================================
// expanded ram array, synchronous read and write
module dmx_xram
  import dmx_pkg::*;
#(
  parameter int DEPTH = DMX_XRAM_DEPTH
) (
  input  wire logic sys_clk_in,
  dmx_xram_if.mem   bus
);
  // refused at elaboration: array deeper than the link can address
  if (DEPTH < 1 || DEPTH > (1 << DMX_XRAM_AW)) begin : g_bad_depth
    $error("depth exceeds address width");
  end

  logic [7:0] mem_q [DEPTH];   // storage, no reset: ram content undefined
  logic [7:0] rdata_reg;       // registered read byte

  // one port: write-first is not needed, core never reads and writes at once
  always_ff @(posedge sys_clk_in) begin
    if (bus.en && bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
    if (bus.en && !bus.we) begin
      rdata_reg <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_reg;
endmodule // dmx_xram

// ### verilog/dmx_top.sv
`timescale 1ns/1ps
// Function
// - pointer access at 0300H up runs bus cycle
// - pointer access below 0300H uses expanded ram
// - register-indirect reaches ram 00H-0FFH, no strobes
// - disable bit set sends everything external
// - register-indirect bus cycle: 8-bit address on port 0
// - pointer bus cycle: high port 2, low port 0
// - write strobe P3.6, read strobe P3.7, low
// - stack pointer covers only internal 256 bytes
// - two pointers, select bit picks one
// - aux one bit 2 reads zero, ignores writes
// - aux one bit 3 plain software flag
// - aux one at A2H, resets 00H, byte only
// - disable bit is bit 1 at 8EH, resets clear
// - ram hits leave ports and strobes untouched
module dmx_top
  import dmx_pkg::*;
#(
  parameter int STROBE_CYC = DMX_STROBE_CYC
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // byte-wide special-function register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // external-move request from the core
  input  wire logic       external_move_instruction_req_in,
  input  wire logic       external_move_instruction_write_in,
  input  wire logic       external_move_instruction_use_ptr_in,
  input  wire logic [7:0] external_move_instruction_ri_addr_in,
  input  wire logic [7:0] external_move_instruction_wdata_in,
  output logic            external_move_instruction_busy_out,
  output logic            external_move_instruction_done_out,
  output logic      [7:0] external_move_instruction_rdata_out,
  // pointer increment and stack operations
  input  wire logic       ptr_inc_in,
  input  wire logic       stack_push_in,
  input  wire logic       stack_pop_in,
  output logic      [7:0] stack_addr_out,
  // external multiplexed bus pins
  input  wire logic [7:0] port0_in,
  output logic      [7:0] port0_out,
  output logic            port0_oe_out,
  output logic      [7:0] port2_out,
  output logic            ale_out,
  output logic            wr_n_out,
  output logic            rd_n_out
);
  // ==========================================================
  // parameter checks, refused at elaboration
  if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : g_bad_strobe
    $error("strobe count out of range");
  end
  // ==========================================================
  // reset release through two flops
  logic rst_meta_reg;  // first stage, read only by second
  logic rst_n_reg;     // synchronised reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end
  // ==========================================================
  // routing decision
  // internal when disable clear and address inside the ram window
  function automatic logic hits_xram(input logic dis, input logic use_ptr,
                                     input logic [15:0] addr);
    if (dis) begin
      hits_xram = 1'b0;
    end else if (use_ptr) begin
      hits_xram = (addr < DMX_XRAM_LIMIT);
    end else begin
      hits_xram = 1'b1;
    end
  endfunction
  // ==========================================================
  // register state
  logic [7:0]  aux0_reg, aux0_next;     // aux_control_zero
  logic [7:0]  aux1_reg, aux1_next;     // aux_control_one
  logic [7:0]  stack_reg, stack_next;   // stack_pointer
  logic [7:0]  port2_reg, port2_next;   // port 2 software latch
  logic [15:0] ptr_reg [2];             // pointer_zero, pointer_one
  logic [15:0] ptr_next [2];
  logic [7:0]  rdata_reg, rdata_next;   // sfr read data
  logic        sel;                     // pointer_select
  logic        xram_dis;                // internal_xram_disable
  assign sel      = aux1_reg[DMX_AUX1_SELECT_BIT];
  assign xram_dis = aux0_reg[DMX_AUX0_DISABLE_BIT];
  // sfr writes, pointer increment, stack moves
  always_comb begin
    aux0_next  = aux0_reg;
    aux1_next  = aux1_reg;
    stack_next = stack_reg;
    port2_next = port2_reg;
    ptr_next   = ptr_reg;
    rdata_next = rdata_reg;
    // increment first so a same-cycle byte write wins
    if (ptr_inc_in) begin
      ptr_next[sel] = ptr_reg[sel] + 16'h0001;
    end
    // stack wraps inside 8 bits, so it never leaves 256 bytes
    if (stack_push_in && !stack_pop_in) begin
      stack_next = stack_reg + 8'h01;
    end else if (stack_pop_in && !stack_push_in) begin
      stack_next = stack_reg - 8'h01;
    end
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        DMX_SFR_AUX_ZERO: begin
          // only the two defined bits are kept
          aux0_next = 8'h00;
          aux0_next[DMX_AUX0_DISABLE_BIT] =
            sfr_wdata_in[DMX_AUX0_DISABLE_BIT];
          aux0_next[DMX_AUX0_ALE_OFF_BIT] =
            sfr_wdata_in[DMX_AUX0_ALE_OFF_BIT];
        end
        DMX_SFR_AUX_ONE: begin
          // whole byte only; zero bit and reserved bits not stored
          aux1_next = 8'h00;
          aux1_next[DMX_AUX1_SELECT_BIT] =
            sfr_wdata_in[DMX_AUX1_SELECT_BIT];
          aux1_next[DMX_AUX1_FLAG_BIT] =
            sfr_wdata_in[DMX_AUX1_FLAG_BIT];
          aux1_next[DMX_AUX1_ZERO_BIT] = 1'b0;
        end
        DMX_SFR_STACK:    stack_next = sfr_wdata_in;
        DMX_SFR_PORT2:    port2_next = sfr_wdata_in;
        DMX_SFR_PTR_LOW:  ptr_next[sel][7:0]  = sfr_wdata_in;
        DMX_SFR_PTR_HIGH: ptr_next[sel][15:8] = sfr_wdata_in;
        default: ; // unmapped: ignored
      endcase
    end
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        DMX_SFR_AUX_ZERO: rdata_next = aux0_reg;
        DMX_SFR_AUX_ONE:  rdata_next = aux1_reg;
        DMX_SFR_STACK:    rdata_next = stack_reg;
        DMX_SFR_PORT2:    rdata_next = port2_reg;
        DMX_SFR_PTR_LOW:  rdata_next = ptr_reg[sel][7:0];
        DMX_SFR_PTR_HIGH: rdata_next = ptr_reg[sel][15:8];
        default:          rdata_next = 8'h00; // unmapped reads zero
      endcase
    end
  end
  // register the sfr group
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      aux0_reg   <= DMX_AUX_ZERO_RST;
      aux1_reg   <= DMX_AUX_ONE_RST;
      stack_reg  <= DMX_STACK_RST;
      port2_reg  <= DMX_PORT2_RST;
      ptr_reg[0] <= DMX_PTR_RST;
      ptr_reg[1] <= DMX_PTR_RST;
      rdata_reg  <= 8'h00;
    end else begin
      aux0_reg   <= aux0_next;
      aux1_reg   <= aux1_next;
      stack_reg  <= stack_next;
      port2_reg  <= port2_next;
      ptr_reg    <= ptr_next;
      rdata_reg  <= rdata_next;
    end
  end
  // ==========================================================
  // access sequencer
  dmx_state_t  st_reg, st_next;
  logic [15:0] addr_reg, addr_next;   // latched access address
  logic        ptr_use_reg, ptr_use_next; // access came from a pointer
  logic        wr_reg, wr_next;       // access is a write
  logic [7:0]  wd_reg, wd_next;       // write byte
  logic [7:0]  md_reg, md_next;       // read byte for the core
  logic [7:0]  cnt_reg, cnt_next;     // strobe width counter
  logic [15:0] req_addr;              // address presented this cycle
  dmx_xram_if #(.AW(DMX_XRAM_AW)) xbus ();
  // selected pointer for pointer moves, zero-extended byte otherwise
  assign req_addr = external_move_instruction_use_ptr_in ? ptr_reg[sel]
                                    : {8'h00, external_move_instruction_ri_addr_in};
  always_comb begin
    st_next      = st_reg;
    addr_next    = addr_reg;
    ptr_use_next = ptr_use_reg;
    wr_next      = wr_reg;
    wd_next      = wd_reg;
    md_next      = md_reg;
    cnt_next     = cnt_reg;
    case (st_reg)
      DMX_IDLE: begin
        if (external_move_instruction_req_in) begin
          addr_next    = req_addr;
          ptr_use_next = external_move_instruction_use_ptr_in;
          wr_next      = external_move_instruction_write_in;
          wd_next      = external_move_instruction_wdata_in;
          st_next      = hits_xram(xram_dis, external_move_instruction_use_ptr_in, req_addr)
                         ? DMX_IRAM : DMX_ADDR;
        end
      end
      DMX_IRAM: st_next = DMX_ICAP;   // ram sees en this cycle
      DMX_ICAP: begin
        if (!wr_reg) begin
          md_next = xbus.rdata;
        end
        st_next = DMX_DONE;
      end
      DMX_ADDR: begin
        cnt_next = 8'(STROBE_CYC - 1);
        st_next  = DMX_STROBE;
      end
      DMX_STROBE: begin
        if (cnt_reg == 8'h00) begin
          // sample before the strobe rises, data still valid
          if (!wr_reg) begin
            md_next = port0_in;
          end
          st_next = DMX_HOLD;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      DMX_HOLD: st_next = DMX_DONE;
      DMX_DONE: st_next = DMX_IDLE;
      default:  st_next = DMX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg      <= DMX_IDLE;
      addr_reg    <= 16'h0000;
      ptr_use_reg <= 1'b0;
      wr_reg      <= 1'b0;
      wd_reg      <= 8'h00;
      md_reg      <= 8'h00;
      cnt_reg     <= 8'h00;
    end else begin
      st_reg      <= st_next;
      addr_reg    <= addr_next;
      ptr_use_reg <= ptr_use_next;
      wr_reg      <= wr_next;
      wd_reg      <= wd_next;
      md_reg      <= md_next;
      cnt_reg     <= cnt_next;
    end
  end
  // ==========================================================
  // expanded ram port
  assign xbus.en    = (st_reg == DMX_IRAM);
  assign xbus.we    = wr_reg;
  assign xbus.addr  = addr_reg[DMX_XRAM_AW-1:0];
  assign xbus.wdata = wd_reg;
  dmx_xram #(.DEPTH(DMX_XRAM_DEPTH)) u_xram (
    .sys_clk_in (sys_clk_in),
    .bus        (xbus)
  );
  // ==========================================================
  // pin drive; ram states take the default branch, so pins hold still
  always_comb begin
    port0_out    = 8'h00;
    port0_oe_out = 1'b0;
    port2_out    = port2_reg;
    ale_out      = 1'b0;
    wr_n_out     = 1'b1;
    rd_n_out     = 1'b1;
    // pointer cycles keep the high byte up from ale to hold
    if (ptr_use_reg && st_reg inside {DMX_ADDR, DMX_STROBE, DMX_HOLD}) begin
      port2_out = addr_reg[15:8];
    end
    case (st_reg)
      DMX_ADDR: begin
        ale_out      = 1'b1;
        port0_out    = addr_reg[7:0];
        port0_oe_out = 1'b1;
      end
      DMX_STROBE, DMX_HOLD: begin
        port0_out    = wd_reg;
        port0_oe_out = wr_reg;
        if (st_reg == DMX_STROBE) begin
          wr_n_out = !wr_reg;
          rd_n_out = wr_reg;
        end
      end
      default: ; // idle and ram states: bus quiet
    endcase
  end
  assign stack_addr_out = stack_reg;
  assign sfr_rdata_out  = rdata_reg;
  assign external_move_instruction_rdata_out = md_reg;
  assign external_move_instruction_done_out  = (st_reg == DMX_DONE);
  assign external_move_instruction_busy_out  = (st_reg != DMX_IDLE);
endmodule // dmx_top

// ### dv/dmx_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the external-move path
module dmx_chk
  import dmx_pkg::*;
#(
  parameter int STROBE_CYC = DMX_STROBE_CYC
) (
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       external_move_instruction_req_in,
  input wire logic       external_move_instruction_write_in,
  input wire logic       external_move_instruction_use_ptr_in,
  input wire logic [7:0] external_move_instruction_ri_addr_in,
  input wire logic [7:0] external_move_instruction_wdata_in,
  input wire logic       external_move_instruction_busy_out,
  input wire logic       external_move_instruction_done_out,
  input wire logic       stack_push_in,
  input wire logic       stack_pop_in,
  input wire logic [7:0] stack_addr_out,
  input wire logic [7:0] port0_out,
  input wire logic       port0_oe_out,
  input wire logic       ale_out,
  input wire logic       wr_n_out,
  input wire logic       rd_n_out
);
  localparam int DONE_EXT = STROBE_CYC + 3; // length of a bus cycle
  logic       take;    // request accepted this edge
  logic       dis_reg; // shadow of the disable bit
  logic [7:0] wd_reg;  // byte of the accepted write
  assign take = external_move_instruction_req_in && !external_move_instruction_busy_out;
  // ==========================================================
  // shadows; the disable bit only changes by a byte write
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dis_reg <= 1'b0;
      wd_reg  <= 8'h00;
    end else begin
      if (sfr_wr_in && sfr_addr_in == DMX_SFR_AUX_ZERO)
        dis_reg <= sfr_wdata_in[DMX_AUX0_DISABLE_BIT];
      if (take)
        wd_reg <= external_move_instruction_wdata_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // assertions
  strobe_excl_a: assert property (!(!wr_n_out && !rd_n_out))
    else $error("both strobes low");
  ri_ram_quiet_a: assert property (
    take && !external_move_instruction_use_ptr_in && !dis_reg |=>
      (rd_n_out && wr_n_out && !ale_out && !port0_oe_out)[*3])
    else $error("ram hit moved the bus");
  ram_done_a: assert property (
    take && !external_move_instruction_use_ptr_in && !dis_reg |-> ##3 external_move_instruction_done_out)
    else $error("ram access length wrong");
  ext_done_a: assert property (
    take && dis_reg |-> ##DONE_EXT external_move_instruction_done_out)
    else $error("bus access length wrong");
  ext_read_a: assert property (
    take && dis_reg && !external_move_instruction_write_in |=> ale_out ##1 (!rd_n_out)[*2]
      ##1 (rd_n_out && !external_move_instruction_done_out) ##1 external_move_instruction_done_out)
    else $error("read strobe sequence wrong");
  ext_write_a: assert property (
    take && dis_reg && external_move_instruction_write_in |=> ##1
      (!wr_n_out && port0_oe_out && port0_out == wd_reg)[*2])
    else $error("write strobe or data wrong");
  ri_addr_a: assert property (
    take && dis_reg && !external_move_instruction_use_ptr_in |=> ale_out && port0_oe_out
      && port0_out == $past(external_move_instruction_ri_addr_in))
    else $error("short address not on port 0");
  aux_one_zero_a: assert property (
    sfr_rd_in && sfr_addr_in == DMX_SFR_AUX_ONE |=>
      (sfr_rdata_out & 8'hF6) == 8'h00)
    else $error("fixed aux bits not zero");
  stack_push_a: assert property (
    stack_push_in && !stack_pop_in |=>
      stack_addr_out == $past(stack_addr_out) + 8'h01)
    else $error("stack push wrong");
  busy_span_a: assert property (
    take && dis_reg |=> external_move_instruction_busy_out[*5] ##1 !external_move_instruction_busy_out)
    else $error("busy span of bus access wrong");
endmodule // dmx_chk

bind dmx_top dmx_chk #(.STROBE_CYC(STROBE_CYC)) i_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .external_move_instruction_req_in(external_move_instruction_req_in),
  .external_move_instruction_write_in(external_move_instruction_write_in), .external_move_instruction_use_ptr_in(external_move_instruction_use_ptr_in),
  .external_move_instruction_ri_addr_in(external_move_instruction_ri_addr_in), .external_move_instruction_wdata_in(external_move_instruction_wdata_in),
  .external_move_instruction_busy_out(external_move_instruction_busy_out), .external_move_instruction_done_out(external_move_instruction_done_out),
  .stack_push_in(stack_push_in), .stack_pop_in(stack_pop_in),
  .stack_addr_out(stack_addr_out), .port0_out(port0_out),
  .port0_oe_out(port0_oe_out), .ale_out(ale_out),
  .wr_n_out(wr_n_out), .rd_n_out(rd_n_out));

// ### dv/dmx_ext_mem.sv
`timescale 1ns/1ps
// ==========================================================
// external byte memory on the multiplexed bus
module dmx_ext_mem (
  input  wire logic       sys_clk_in,
  input  wire logic       ale_in,   // address phase
  input  wire logic [7:0] lo_in,    // port 0 from the core
  input  wire logic       oe_in,    // core drives port 0
  input  wire logic [7:0] hi_in,    // port 2
  input  wire logic       wr_n_in,  // write strobe, low
  input  wire logic       rd_n_in,  // read strobe, low
  output logic      [7:0] data_out  // port 0 back to the core
);
  logic [7:0]  mem [0:65535];     // whole 64 kB space
  logic [15:0] addr_reg;          // latched address
  logic [7:0]  last_reg = 8'h00;  // last byte driven
  // latch on ale, store while the write strobe is low
  always @(posedge sys_clk_in) begin
    if (ale_in)
      addr_reg <= {hi_in, lo_in};
    if (!wr_n_in && oe_in)
      mem[addr_reg] <= lo_in;
    if (!rd_n_in)
      last_reg <= data_out;
  end
  // released bus shows the inverse, so a late sample cannot pass
  assign data_out = !rd_n_in ? mem[addr_reg] : ~last_reg;
endmodule // dmx_ext_mem

// ### dv/tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the data-memory path
module tb;
  import dmx_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, seen = 1'b0; // seen: bus moved
  logic [7:0] sa = 8'h00, sd = 8'h00, ri = 8'h00, wd = 8'h00;
  logic       sw = 1'b0, sr = 1'b0, req = 1'b0, wr = 1'b0, up = 1'b0;
  logic       inc = 1'b0, push = 1'b0, pop = 1'b0;
  logic [7:0] srd, rdat, sp, p0i, p0o, p2;
  logic       busy, done, oe, ale, wrn, rdn;
  int         errors = 0, checked = 0;
  dmx_top i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(sa),
    .sfr_wr_in(sw), .sfr_rd_in(sr), .sfr_wdata_in(sd), .sfr_rdata_out(srd),
    .external_move_instruction_req_in(req), .external_move_instruction_write_in(wr), .external_move_instruction_use_ptr_in(up),
    .external_move_instruction_ri_addr_in(ri), .external_move_instruction_wdata_in(wd), .external_move_instruction_busy_out(busy),
    .external_move_instruction_done_out(done), .external_move_instruction_rdata_out(rdat), .ptr_inc_in(inc),
    .stack_push_in(push), .stack_pop_in(pop), .stack_addr_out(sp),
    .port0_in(p0i), .port0_out(p0o), .port0_oe_out(oe), .port2_out(p2),
    .ale_out(ale), .wr_n_out(wrn), .rd_n_out(rdn));
  dmx_ext_mem i_mem (.sys_clk_in(clk), .ale_in(ale), .lo_in(p0o),
    .oe_in(oe), .hi_in(p2), .wr_n_in(wrn), .rd_n_in(rdn), .data_out(p0i));
  initial forever #2.5 clk = ~clk;
  // any strobe or ale during an access marks it as a bus cycle
  always @(negedge clk) if (wrn === 1'b0 || rdn === 1'b0 || ale === 1'b1)
    seen = 1'b1;
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sa <= a;
    sd <= d;
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sa <= a;
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
    #1 chk(srd, e);
  endtask
  // one external move; ext says whether the bus must move
  task automatic external_move_instruction(input logic w, p, input logic [7:0] a, d, e,
                      input logic ext);
    int n;
    seen = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    wr  <= w;
    up  <= p;
    ri  <= a;
    wd  <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 20);
    chk({7'h00, done}, 8'h01);
    chk({7'h00, seen}, {7'h00, ext});
    if (!w)
      chk(rdat, e);
  endtask
  task automatic close_out();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    i_mem.mem[16'h1234] = 8'h66;
    i_mem.mem[16'h00FF] = 8'hC3;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    sfr_rd(DMX_SFR_AUX_ZERO, 8'h00);
    sfr_rd(DMX_SFR_AUX_ONE, 8'h00);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h0D);
    sfr_rd(DMX_SFR_AUX_ONE, 8'h09);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h00);
    sfr_wr(DMX_SFR_PTR_LOW, 8'h34);
    sfr_wr(DMX_SFR_PTR_HIGH, 8'h12);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h01);
    sfr_wr(DMX_SFR_PTR_LOW, 8'hFF);
    sfr_wr(DMX_SFR_PTR_HIGH, 8'h02);
    sfr_rd(DMX_SFR_PTR_LOW, 8'hFF);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h00);
    sfr_rd(DMX_SFR_PTR_HIGH, 8'h12);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h01);
    external_move_instruction(1'b1, 1'b1, 8'h00, 8'h5A, 8'h00, 1'b0);
    external_move_instruction(1'b0, 1'b1, 8'h00, 8'h00, 8'h5A, 1'b0);
    @(posedge clk);
    inc <= 1'b1;
    @(posedge clk);
    inc <= 1'b0;
    external_move_instruction(1'b1, 1'b1, 8'h00, 8'hA5, 8'h00, 1'b1);
    chk(i_mem.mem[16'h0300], 8'hA5);
    sfr_wr(DMX_SFR_AUX_ONE, 8'h00);
    external_move_instruction(1'b0, 1'b1, 8'h00, 8'h00, 8'h66, 1'b1);
    external_move_instruction(1'b1, 1'b0, 8'hFF, 8'h3C, 8'h00, 1'b0);
    sfr_wr(DMX_SFR_PTR_LOW, 8'hFF);
    sfr_wr(DMX_SFR_PTR_HIGH, 8'h00);
    external_move_instruction(1'b0, 1'b1, 8'h00, 8'h00, 8'h3C, 1'b0);
    sfr_wr(DMX_SFR_AUX_ZERO, 8'h03);
    sfr_rd(DMX_SFR_AUX_ZERO, 8'h03);
    external_move_instruction(1'b1, 1'b0, 8'h10, 8'h77, 8'h00, 1'b1);
    chk(i_mem.mem[16'hFF10], 8'h77);
    external_move_instruction(1'b0, 1'b1, 8'h00, 8'h00, 8'hC3, 1'b1);
    @(posedge clk);
    push <= 1'b1;
    repeat (2) @(posedge clk);
    push <= 1'b0;
    #1 chk(sp, 8'h09);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    #1 chk(sp, 8'h08);
    close_out();
  end
  // hang guard: the whole run needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule // tb
